/* File: core/isa_regs.vh */
// Constants shared by the interrupt source arbiter: register map, field layout,
// reset values, source numbering and vector table addresses.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef ISA_REGS_VH
`define ISA_REGS_VH

`define ISA_NSRC 11
`define ISA_NPIN 3
`define ISA_AW 12

`define ISA_ADDR_CTRL 12'h000
`define ISA_ADDR_REQ 12'h004
`define ISA_ADDR_MASK 12'h008
`define ISA_ADDR_PRIO 12'h00C
`define ISA_ADDR_EDGE 12'h010
`define ISA_ADDR_STAT 12'h014

`define ISA_CTRL_GIE 0
`define ISA_CTRL_WDTNMI 1
`define ISA_CTRL_ISP 2

`define ISA_MASK_RST 11'h7ff
`define ISA_PRIO_RST 11'h7ff
`define ISA_EDGE_RST 6'h00
`define ISA_ZERO32 32'h0000_0000

`define ISA_SRC_WDT 0
`define ISA_SRC_P1 1
`define ISA_SRC_P2 2
`define ISA_SRC_P3 3
`define ISA_SRC_SER 4
`define ISA_SRC_SR 5
`define ISA_SRC_CSI 6
`define ISA_SRC_ST 7
`define ISA_SRC_AD 8
`define ISA_SRC_TM5 9
`define ISA_SRC_TM6 10

`define ISA_VEC_NMI 16'h0004
`define ISA_VEC_WDT 16'h0004
`define ISA_VEC_P1 16'h0008
`define ISA_VEC_P2 16'h000A
`define ISA_VEC_P3 16'h000C
`define ISA_VEC_SER 16'h0018
`define ISA_VEC_SR 16'h001A
`define ISA_VEC_ST 16'h001C
`define ISA_VEC_AD 16'h0028
`define ISA_VEC_TM5 16'h002A
`define ISA_VEC_TM6 16'h002C
`define ISA_VEC_BRK 16'h003E

`define ISA_KIND_MASKABLE 2'h0
`define ISA_KIND_NMI 2'h1
`define ISA_KIND_SOFT 2'h2

`endif

/* File: core/isa_edge_detect.v */
// Edge detector for one external interrupt pin.
// Assumes the pin is asynchronous to pclk; it is synchronised here first.
`timescale 1ns/1ns
module isa_edge_detect
(
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Pin and edge selection.
    input wire pin,
    input wire rise_en,
    input wire fall_en,
    // One-cycle pulse per selected edge.
    output wire edge_pulse
);
    reg sync_a;
    reg sync_b;
    reg last;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last <= 1'b0;
        end
        else
        begin
            sync_a <= pin;
            sync_b <= sync_a;
            last <= sync_b;
        end
    end

    // Both enables set gives detection on either edge.
    assign edge_pulse = (rise_en & sync_b & ~last) | (fall_en & ~sync_b & last);
endmodule

/* File: core/isa_prio.v */
// Fixed priority picker over the maskable sources: lowest index wins.
// Assumes the source index equals the default priority order.
`timescale 1ns/1ns
`include "isa_regs.vh"
module isa_prio
(
    // Candidate requests.
    input wire [`ISA_NSRC-1:0] req,
    // Winner.
    output reg [3:0] idx,
    output reg found
);
    integer i;

    always @*
    begin
        idx = 4'h0;
        found = 1'b0;
        // Scanning downward leaves the smallest index, so ties favour the higher rank.
        for (i = `ISA_NSRC - 1; i >= 0; i = i - 1)
        begin
            if (req[i])
            begin
                idx = i[3:0];
                found = 1'b1;
            end
        end
    end
endmodule

/* File: core/isa_top.v */
// Interrupt source arbiter: collects the non-maskable, maskable and software
// sources, ranks them and presents one vector at a time to the processor core.
// Assumes internal sources are one-cycle pulses on pclk, external pins are
// asynchronous, and the core answers each presented request with core_ack.
`timescale 1ns/1ns
`include "isa_regs.vh"
module isa_top
(
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ISA_AW-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Interrupt sources.
    input wire wdt_overflow_irq,
    input wire [`ISA_NPIN-1:0] ext_irq_pin,
    input wire uart_rx_error_irq,
    input wire uart_rx_done_irq,
    input wire sio_done_irq,
    input wire uart_tx_done_irq,
    input wire adc_done_irq,
    input wire timer_a_match_irq,
    input wire timer_b_match_irq,
    input wire soft_break_instruction,
    // Processor core side.
    output reg core_req,
    output reg [1:0] core_kind,
    output reg [15:0] core_vector,
    input wire core_ack
);
    localparam ST_IDLE = 1'b0;
    localparam ST_PRESENT = 1'b1;

    reg state;
    reg global_enable_flag;
    reg wdt_nmi_mode;
    reg in_service_level_flag;
    reg [`ISA_NSRC-1:0] request_flag;
    reg [`ISA_NSRC-1:0] mask_flag;
    reg [`ISA_NSRC-1:0] priority_group_flag;
    reg [2*`ISA_NPIN-1:0] edge_sel;
    reg nmi_pend;
    reg soft_pend;
    reg [3:0] cur_idx;
    reg cur_high;

    wire [`ISA_NPIN-1:0] pin_pulse;
    wire [`ISA_NSRC-1:0] trig;
    wire [`ISA_NSRC-1:0] sw_clr;
    wire [`ISA_NSRC-1:0] ack_clr;
    wire [`ISA_NSRC-1:0] eligible;
    wire [`ISA_NSRC-1:0] high_elig;
    wire [`ISA_NSRC-1:0] pick_vec;
    wire [3:0] win_idx;
    wire win_found;
    wire apb_done;
    wire wr_en;
    wire ack_taken;
    wire ack_mask;
    wire ack_nmi;
    wire ack_soft;
    wire wr_ctrl;
    wire wr_req;
    wire wr_mask;
    wire wr_prio;
    wire wr_edge;

    // A transfer completes on the edge where the registered pready is seen high.
    assign apb_done = psel & penable & pready;
    assign wr_en = apb_done & pwrite;
    assign ack_taken = (state == ST_PRESENT) & core_ack;
    assign ack_mask = ack_taken & (core_kind == `ISA_KIND_MASKABLE);
    assign ack_nmi = ack_taken & (core_kind == `ISA_KIND_NMI);
    assign ack_soft = ack_taken & (core_kind == `ISA_KIND_SOFT);

    // One write strobe per writable register, so no software write lands outside the completing edge.
    assign wr_ctrl = wr_en & (paddr == `ISA_ADDR_CTRL);
    assign wr_req = wr_en & (paddr == `ISA_ADDR_REQ);
    assign wr_mask = wr_en & (paddr == `ISA_ADDR_MASK);
    assign wr_prio = wr_en & (paddr == `ISA_ADDR_PRIO);
    assign wr_edge = wr_en & (paddr == `ISA_ADDR_EDGE);

    // Each detector synchronises its pin before any edge logic reads it.
    genvar g;
    generate
        for (g = 0; g < `ISA_NPIN; g = g + 1)
        begin : pin_edge
            isa_edge_detect u_edge
            (
                .pclk(pclk),
                .presetn(presetn),
                .pin(ext_irq_pin[g]),
                .rise_en(edge_sel[2*g]),
                .fall_en(edge_sel[2*g+1]),
                .edge_pulse(pin_pulse[g])
            );
        end
    endgenerate

    // Source positions follow the default priority, so the index is the rank.
    assign trig[`ISA_SRC_WDT] = wdt_overflow_irq & ~wdt_nmi_mode;
    assign trig[`ISA_SRC_P1] = pin_pulse[0];
    assign trig[`ISA_SRC_P2] = pin_pulse[1];
    assign trig[`ISA_SRC_P3] = pin_pulse[2];
    assign trig[`ISA_SRC_SER] = uart_rx_error_irq;
    assign trig[`ISA_SRC_SR] = uart_rx_done_irq;
    assign trig[`ISA_SRC_CSI] = sio_done_irq;
    assign trig[`ISA_SRC_ST] = uart_tx_done_irq;
    assign trig[`ISA_SRC_AD] = adc_done_irq;
    assign trig[`ISA_SRC_TM5] = timer_a_match_irq;
    assign trig[`ISA_SRC_TM6] = timer_b_match_irq;

    assign sw_clr = wr_req ? pwdata[`ISA_NSRC-1:0] : {`ISA_NSRC{1'b0}};

    // Request flags: a trigger in the clearing cycle still leaves the flag set.
    generate
        for (g = 0; g < `ISA_NSRC; g = g + 1)
        begin : req_bit
            assign ack_clr[g] = ack_mask & (cur_idx == g);
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    request_flag[g] <= 1'b0;
                else
                    request_flag[g] <= trig[g] | (request_flag[g] & ~sw_clr[g] & ~ack_clr[g]);
            end
        end
    endgenerate

    // Low group is shut out while a high-group service is in progress.
    assign eligible = request_flag & ~mask_flag & (in_service_level_flag ? ~priority_group_flag
                      : {`ISA_NSRC{1'b1}});
    assign high_elig = eligible & ~priority_group_flag;
    assign pick_vec = (|high_elig) ? high_elig : eligible;

    isa_prio u_prio
    (
        .req(pick_vec),
        .idx(win_idx),
        .found(win_found)
    );

    function [15:0] vec_of;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: vec_of = `ISA_VEC_WDT;
                4'h1: vec_of = `ISA_VEC_P1;
                4'h2: vec_of = `ISA_VEC_P2;
                4'h3: vec_of = `ISA_VEC_P3;
                4'h4: vec_of = `ISA_VEC_SER;
                4'h5: vec_of = `ISA_VEC_SR;
                4'h6: vec_of = `ISA_VEC_SR;
                4'h7: vec_of = `ISA_VEC_ST;
                4'h8: vec_of = `ISA_VEC_AD;
                4'h9: vec_of = `ISA_VEC_TM5;
                4'hA: vec_of = `ISA_VEC_TM6;
                default: vec_of = `ISA_VEC_WDT;
            endcase
        end
    endfunction

    // Non-maskable and software pending flags; set wins over acknowledge.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_pend <= 1'b0;
            soft_pend <= 1'b0;
        end
        else
        begin
            nmi_pend <= (wdt_overflow_irq & wdt_nmi_mode) |
                        (nmi_pend & ~ack_nmi);
            soft_pend <= soft_break_instruction |
                         (soft_pend & ~ack_soft);
        end
    end

    // Presentation: one request stands until the core acknowledges it.
    // A presented maskable request is not withdrawn if software masks it later.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            core_req <= 1'b0;
            core_kind <= `ISA_KIND_MASKABLE;
            core_vector <= 16'h0000;
            cur_idx <= 4'h0;
            cur_high <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (nmi_pend)
                    begin
                        state <= ST_PRESENT;
                        core_req <= 1'b1;
                        core_kind <= `ISA_KIND_NMI;
                        core_vector <= `ISA_VEC_NMI;
                    end
                    else if (soft_pend)
                    begin
                        state <= ST_PRESENT;
                        core_req <= 1'b1;
                        core_kind <= `ISA_KIND_SOFT;
                        core_vector <= `ISA_VEC_BRK;
                    end
                    else if (win_found && global_enable_flag)
                    begin
                        state <= ST_PRESENT;
                        core_req <= 1'b1;
                        core_kind <= `ISA_KIND_MASKABLE;
                        core_vector <= vec_of(win_idx);
                        cur_idx <= win_idx;
                        cur_high <= ~priority_group_flag[win_idx];
                    end
                end
                ST_PRESENT:
                begin
                    if (core_ack)
                    begin
                        state <= ST_IDLE;
                        core_req <= 1'b0;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                    core_req <= 1'b0;
                end
            endcase
        end
    end

    // Control registers; the in-service flag is set by a high-group acknowledge
    // and that set wins over a software write in the same cycle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            global_enable_flag <= 1'b0;
            wdt_nmi_mode <= 1'b0;
            in_service_level_flag <= 1'b0;
            mask_flag <= `ISA_MASK_RST;
            priority_group_flag <= `ISA_PRIO_RST;
            edge_sel <= `ISA_EDGE_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                global_enable_flag <= pwdata[`ISA_CTRL_GIE];
                wdt_nmi_mode <= pwdata[`ISA_CTRL_WDTNMI];
                in_service_level_flag <= pwdata[`ISA_CTRL_ISP];
            end
            if (ack_mask && cur_high)
                in_service_level_flag <= 1'b1;
            if (wr_mask)
                mask_flag <= pwdata[`ISA_NSRC-1:0];
            if (wr_prio)
                priority_group_flag <= pwdata[`ISA_NSRC-1:0];
            if (wr_edge)
                edge_sel <= pwdata[2*`ISA_NPIN-1:0];
        end
    end

    // APB answer: one wait state, so pready rises on the second access cycle.
    reg [31:0] next_prdata;
    reg next_err;

    // Read images, each padded with explicit zero fields to exactly the bus width.
    wire [31:0] ctrl_image;
    wire [31:0] req_image;
    wire [31:0] mask_image;
    wire [31:0] prio_image;
    wire [31:0] edge_image;
    wire [31:0] stat_image;

    assign ctrl_image = {29'h0000_0000, in_service_level_flag, wdt_nmi_mode, global_enable_flag};
    assign req_image = {21'h00_0000, request_flag};
    assign mask_image = {21'h00_0000, mask_flag};
    assign prio_image = {21'h00_0000, priority_group_flag};
    assign edge_image = {26'h000_0000, edge_sel};
    assign stat_image = {8'h00, core_vector, cur_idx, soft_pend, nmi_pend, core_req, state};

    always @*
    begin
        next_prdata = `ISA_ZERO32;
        next_err = 1'b0;
        case (paddr)
            `ISA_ADDR_CTRL: next_prdata = ctrl_image;
            `ISA_ADDR_REQ: next_prdata = req_image;
            `ISA_ADDR_MASK: next_prdata = mask_image;
            `ISA_ADDR_PRIO: next_prdata = prio_image;
            `ISA_ADDR_EDGE: next_prdata = edge_image;
            `ISA_ADDR_STAT: next_prdata = stat_image;
            default: next_err = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `ISA_ZERO32;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_err;
            if (psel && penable && !pready && !pwrite)
                prdata <= next_prdata;
        end
    end
endmodule

/* File: dv/isa_checker.sv */
// Port-level assertions for the interrupt source arbiter.
// Assumes it is bound to isa_top and sees only that module's ports.
`timescale 1ns/1ns
module isa_checker
(
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire pready,
    input wire pslverr,
    // Processor core side.
    input wire core_req,
    input wire [1:0] core_kind,
    input wire [15:0] core_vector,
    input wire core_ack
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_first_access;
        psel && penable && !$past(penable);
    endsequence
    sequence s_one_wait;
        !pready ##1 pready;
    endsequence
    sequence s_presented;
        core_req && !core_ack;
    endsequence

    a_apb_one_wait: assert property (s_first_access |-> s_one_wait)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C,
        12'h010, 12'h014}))
        else $error("pslverr does not match address map");
    a_req_stands: assert property (s_presented |=> core_req && $stable(core_vector) && $stable(core_kind))
        else $error("request changed before acknowledge");
    a_ack_drops: assert property (core_req && core_ack |=> !core_req)
        else $error("request stayed after acknowledge");
    a_nmi_vector: assert property (core_req && core_kind == 2'h1 |-> core_vector == 16'h0004)
        else $error("non-maskable vector wrong");
    a_soft_vector: assert property (core_req && core_kind == 2'h2 |-> core_vector == 16'h003E)
        else $error("software vector wrong");
    a_kind_legal: assert property (core_req |-> core_kind != 2'h3)
        else $error("unknown request class");
    a_mask_vector: assert property (core_req && core_kind == 2'h0 |-> core_vector inside
        {16'h0004, 16'h0008, 16'h000A, 16'h000C, 16'h0018, 16'h001A, 16'h001C, 16'h0028, 16'h002A, 16'h002C})
        else $error("maskable vector outside table");
endmodule

bind isa_top isa_checker u_checker
(
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .core_req(core_req),
    .core_kind(core_kind),
    .core_vector(core_vector),
    .core_ack(core_ack)
);

/* File: dv/isa_core_model.sv */
// Processor core model: acknowledges each presented request after a delay.
// Assumes ack_delay stays steady while a request stands.
`timescale 1ns/1ns
module isa_core_model
(
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Request from the arbiter and chosen latency.
    input wire core_req,
    input wire [3:0] ack_delay,
    output reg core_ack
);
    reg [3:0] wait_count;

    // The acknowledge is one cycle wide, so a request is never taken twice.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_ack <= 1'b0;
            wait_count <= 4'h0;
        end
        else if (core_req && !core_ack && wait_count == ack_delay)
        begin
            core_ack <= 1'b1;
            wait_count <= 4'h0;
        end
        else
        begin
            core_ack <= 1'b0;
            wait_count <= (core_req && !core_ack) ? wait_count + 4'h1 : 4'h0;
        end
    end
endmodule

/* File: dv/isa_top_bench.sv */
// Self-checking bench for the interrupt source arbiter.
// Assumes the core model acknowledges every request; APB has one wait state.
`timescale 1ns/1ns
module isa_top_bench;
    reg pclk, presetn, psel, penable, pwrite, er;
    reg [11:0] paddr, src, m;
    reg [31:0] pwdata, rd, seed;
    reg [2:0] pins;
    reg [3:0] ack_delay;
    wire [31:0] prdata;
    wire pready, pslverr, core_req, core_ack;
    wire [1:0] core_kind;
    wire [15:0] core_vector;
    integer bad_count, checks, i, k;

    isa_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdt_overflow_irq(src[0]), .ext_irq_pin(pins), .uart_rx_error_irq(src[4]),
        .uart_rx_done_irq(src[5]), .sio_done_irq(src[6]), .uart_tx_done_irq(src[7]),
        .adc_done_irq(src[8]), .timer_a_match_irq(src[9]), .timer_b_match_irq(src[10]),
        .soft_break_instruction(src[11]), .core_req(core_req), .core_kind(core_kind),
        .core_vector(core_vector), .core_ack(core_ack));
    isa_core_model core (.pclk(pclk), .presetn(presetn), .core_req(core_req),
        .ack_delay(ack_delay), .core_ack(core_ack));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Vector table address of a maskable source, by default priority position.
    function [15:0] exp_vec(input integer s);
    begin
        case (s)
            0: exp_vec = 16'h0004;
            1: exp_vec = 16'h0008;
            2: exp_vec = 16'h000A;
            3: exp_vec = 16'h000C;
            4: exp_vec = 16'h0018;
            5, 6: exp_vec = 16'h001A;
            7: exp_vec = 16'h001C;
            8: exp_vec = 16'h0028;
            9: exp_vec = 16'h002A;
            default: exp_vec = 16'h002C;
        endcase
    end
    endfunction

    // Reset image of the register at word index r: mask and group registers start all ones.
    function [31:0] exp_rst(input integer r);
        exp_rst = (r == 2 || r == 3) ? 32'h0000_07ff : 32'h0000_0000;
    endfunction

    task results;
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task hang;
    begin
        bad_count = bad_count + 1;
        results;
    end
    endtask

    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
    begin
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        if (pready !== 1'b1)
            hang;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    // Waits for a presented request, compares it, then waits for it to clear.
    task take(input [15:0] v, input [1:0] kd);
        integer n;
    begin
        n = 0;
        while (core_req !== 1'b1 && n < 30)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        if (core_req !== 1'b1)
            hang;
        chk(core_vector, v);
        chk(core_kind, kd);
        while (core_req !== 1'b0 && n < 60)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        if (core_req !== 1'b0)
            hang;
    end
    endtask

    task pulse(input [11:0] p);
    begin
        @(posedge pclk);
        src <= p;
        @(posedge pclk);
        src <= 12'h000;
    end
    endtask

    task quiet;
        repeat (8)
        begin
            @(posedge pclk);
            chk(core_req, 1'h0);
        end
    endtask

    initial
    begin
        bad_count = 0;
        checks = 0;
        seed = 32'ha480;
        {presetn, psel, penable, pwrite, paddr, pwdata, src, pins, ack_delay} = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 6; i = i + 1)
        begin
            apb(1'h0, i * 4, 1'h0);
            chk(rd, exp_rst(i));
        end
        apb(1'h0, 12'h018, 1'h0);
        chk(er, 1'h1);
        chk(rd, 1'h0);
        apb(1'h1, 12'h000, 1'h1);
        apb(1'h1, 12'h008, 1'h0);
        apb(1'h1, 12'h010, 6'h3f);
        // Random sets of simultaneous internal sources, first one with all eight at once.
        for (k = 0; k < 8; k = k + 1)
        begin
            seed = lfsr(seed);
            ack_delay <= seed[15:12];
            m = (k == 0) ? 12'h7f1 : seed[11:0] & 12'h7f1;
            pulse(m);
            for (i = 0; i < 11; i = i + 1)
                if (m[i])
                    take(exp_vec(i), 2'h0);
        end
        for (i = 0; i < 6; i = i + 1)
        begin
            pins <= pins ^ (3'h1 << (i % 3));
            take(exp_vec(i % 3 + 1), 2'h0);
        end
        apb(1'h1, 12'h010, 6'h01);
        pins <= 3'h1;
        take(16'h0008, 2'h0);
        pins <= 3'h0;
        quiet;
        apb(1'h1, 12'h008, 11'h100);
        pulse(12'h100);
        quiet;
        apb(1'h0, 12'h004, 1'h0);
        chk(rd, 11'h100);
        apb(1'h1, 12'h008, 1'h0);
        take(16'h0028, 2'h0);
        apb(1'h0, 12'h004, 1'h0);
        chk(rd, 1'h0);
        apb(1'h1, 12'h000, 1'h0);
        pulse(12'h200);
        quiet;
        apb(1'h1, 12'h000, 1'h1);
        take(16'h002A, 2'h0);
        apb(1'h1, 12'h00c, 11'h6ff);
        pulse(12'h100);
        take(16'h0028, 2'h0);
        apb(1'h0, 12'h000, 1'h0);
        chk(rd, 3'h5);
        pulse(12'h400);
        quiet;
        apb(1'h1, 12'h000, 1'h1);
        take(16'h002C, 2'h0);
        apb(1'h1, 12'h000, 2'h3);
        ack_delay <= 4'hf;
        pulse(12'h001);
        apb(1'h0, 12'h014, 1'h0);
        chk(rd, 32'h0000_04a7);
        take(16'h0004, 2'h1);
        pulse(12'h800);
        take(16'h003E, 2'h2);
        results;
    end
endmodule
